// >>> host_pins.sv
`timescale 1ns/1ps
`default_nettype none
module host_pins (
    // clock and requests
    input wire logic       ref_clk,
    input wire logic       rst_go,
    input wire logic [7:0] rst_len,
    input wire logic       lp_req,
    // pins towards the module
    output logic           module_reset_n,
    output logic           low_power_select_pin
);
    logic [7:0] cnt_q, cnt_d;
    always_comb begin
        cnt_d = rst_go ? rst_len : cnt_q - {7'h00, cnt_q != 8'h00};
    end
    // pin held low for the requested length; a new request reloads the count, even a shorter one
    always_ff @(posedge ref_clk) begin
        cnt_q                <= cnt_d;
        module_reset_n       <= (cnt_d == 8'h00);
        low_power_select_pin <= lp_req;
    end
endmodule : host_pins
`default_nettype wire

// >>> mgmt_pkg.sv
`default_nettype none
package mgmt_pkg;
    typedef enum logic [1:0] {
        PWR_INIT,
        PWR_READY,
        PWR_LOW,
        PWR_RESET
    } pwr_state_t;

    // latched event flags, bit 0 is the readiness event
    typedef struct packed {
        logic [3:0] other;
        logic [3:0] tx_fault;
        logic [3:0] rx_los;
        logic       ready;
    } flag_vec_t;

    typedef struct packed {
        logic       app_sel;
        logic [1:0] rate_sel;
        logic       pdown;
    } ctrl_t;

    typedef struct packed {
        logic       reset_n;
        logic       low_power;
        logic [3:0] rx_los;
        logic [3:0] tx_fault;
        logic [3:0] other;
    } pin_vec_t;
endpackage : mgmt_pkg
`default_nettype wire

// >>> mgmt_regs.svh
`ifndef MGMT_REGS_SVH
`define MGMT_REGS_SVH
// ==========================================
// clock and timing
`define CLK_HZ          20000000
`define CYC_PER_MS      (`CLK_HZ / 1000)
`define CYC_PER_US      (`CLK_HZ / 1000000)
`define T_INIT_MS       2000
`define T_LP_EXIT_MS    300
`define T_PDOWN_EXIT_MS 300
`define T_RESET_MIN_US  2
`define RESET_MIN_CYC   (`T_RESET_MIN_US * `CYC_PER_US)
`define CNT_W           26
// ==========================================
// register byte offsets
`define OFS_STATUS      6'h00
`define OFS_FLAGS       6'h04
`define OFS_MASK        6'h08
`define OFS_CONTROL     6'h0c
// ==========================================
// fields and reset values
`define ST_NOT_READY    0
`define ST_LOW_POWER    1
`define ST_IN_RESET     2
`define FLAG_W          13
`define CTRL_W          4
`define MASK_RESET      13'h0000
`define CTRL_RESET      4'h0
`endif

// >>> mgmt_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_sva
    import mgmt_pkg::*;
#(
    parameter int INIT_CYCLES = 50
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // register bus
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // pins
    input wire logic        module_reset_n,
    input wire logic [3:0]  rx_los_in,
    input wire logic [3:0]  tx_fault_in,
    input wire logic [3:0]  other_cond_in,
    // outputs
    input wire logic        interrupt_request_n,
    input wire logic        power_level1,
    input wire logic        module_ready,
    input wire logic        in_reset,
    input wire logic [1:0]  rate_sel_out,
    input wire logic        app_sel_out
);
    // ==========================================
    // helper state
    localparam int INIT_LIM = INIT_CYCLES + 8;
    logic [11:0] cond_q;
    logic [12:0] mask_q;
    logic [5:0]  low_q;
    logic        wr_done;
    logic        rd_flags;
    assign wr_done  = avs_write && !avs_waitrequest;
    assign rd_flags = avs_read && !avs_waitrequest && avs_address == 6'h04;
    // mask snooped from the bus, so the checker needs no internal probes
    always_ff @(posedge ref_clk) begin
        cond_q <= {other_cond_in, tx_fault_in, rx_los_in};
        low_q  <= module_reset_n ? 6'h00 : low_q + {5'h00, low_q != 6'h3f};
        if (sys_rst)
            mask_q <= 13'h0000;
        else if (wr_done && avs_address == 6'h08)
            mask_q <= avs_writedata[12:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // assertions
    init_ready_a: assert property ($fell(sys_rst) |-> ##[1:INIT_LIM] module_ready)
        else $error("not ready in time after reset");
    ready_irq_a: assert property ($rose(module_ready) && !mask_q[0] |-> !interrupt_request_n)
        else $error("ready without interrupt");
    cond_irq_a: assert property ((({other_cond_in, tx_fault_in, rx_los_in} & ~cond_q
        & ~mask_q[12:1]) != 12'h000) && !in_reset |-> ##[1:5] !interrupt_request_n)
        else $error("condition did not raise interrupt");
    irq_hold_a: assert property (!interrupt_request_n && !in_reset && !rd_flags
        && !(wr_done && avs_address == 6'h08) |=> !interrupt_request_n || in_reset)
        else $error("interrupt released without cause");
    mask_all_a: assert property (wr_done && avs_address == 6'h08
        && avs_writedata[12:0] == 13'h1fff |=> interrupt_request_n)
        else $error("masked flags still interrupt");
    sel_copy_a: assert property (wr_done && avs_address == 6'h0c |=>
        rate_sel_out == $past(avs_writedata[2:1]) && app_sel_out == $past(avs_writedata[3]))
        else $error("select outputs not updated");
    pdown_enter_a: assert property (wr_done && avs_address == 6'h0c && avs_writedata[0]
        && !in_reset |-> ##[1:2] power_level1)
        else $error("power down not entered");
    rst_min_a: assert property ($rose(in_reset) |-> low_q >= 6'h28)
        else $error("reset recognised too early");
    rst_ready_a: assert property ($fell(in_reset) |-> ##[1:INIT_LIM] module_ready)
        else $error("not ready after pin reset");
    bus_answer_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus did not answer");
    cover property (wr_done && avs_address == 6'h08);
    cover property ($rose(in_reset));
    cover property ($rose(power_level1));
endmodule : mgmt_sva
bind module_mgmt_event_power_timing mgmt_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
    .ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_waitrequest, .module_reset_n, .rx_los_in, .tx_fault_in, .other_cond_in,
    .interrupt_request_n, .power_level1, .module_ready, .in_reset, .rate_sel_out,
    .app_sel_out);
`default_nettype wire

// >>> module_mgmt_event_power_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_regs.svh"

module module_mgmt_event_power_timing
    import mgmt_pkg::*;
#(
    parameter int INIT_CYCLES    = `T_INIT_MS * `CYC_PER_MS,
    parameter int LP_EXIT_CYCLES = `T_LP_EXIT_MS * `CYC_PER_MS
) (
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // pins from the host and the optics
    input  wire logic        module_reset_n,
    input  wire logic        low_power_select_pin,
    input  wire logic [3:0]  rx_los_in,
    input  wire logic [3:0]  tx_fault_in,
    input  wire logic [3:0]  other_cond_in,
    // module outputs
    output logic             interrupt_request_n,
    output logic             power_level1,
    output logic             module_ready,
    output logic             in_reset,
    output logic [1:0]       rate_sel_out,
    output logic             app_sel_out
);
    // ==========================================
    // functions
    function automatic logic cnt_done(input logic [`CNT_W-1:0] c, input int lim);
        cnt_done = (32'(c) + 32'd1 >= 32'(lim));
    endfunction : cnt_done

    // ==========================================
    // pin synchroniser
    pin_vec_t pins_raw;
    pin_vec_t sync1_q;
    pin_vec_t sync2_q;
    pin_vec_t prev_q;
    pin_vec_t sync1_d;
    pin_vec_t sync2_d;
    pin_vec_t prev_d;
    localparam pin_vec_t PIN_IDLE = '{reset_n: 1'b1, low_power: 1'b0,
                                     rx_los: 4'h0, tx_fault: 4'h0, other: 4'h0};

    assign pins_raw = '{reset_n: module_reset_n, low_power: low_power_select_pin,
                        rx_los: rx_los_in, tx_fault: tx_fault_in,
                        other: other_cond_in};

    always_comb begin
        sync1_d = sync1_q;
        sync2_d = sync2_q;
        prev_d  = prev_q;
        if (clk_en) begin
            sync1_d = pins_raw;
            sync2_d = sync1_q;
            prev_d  = sync2_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_q <= PIN_IDLE;
            sync2_q <= PIN_IDLE;
            prev_q  <= PIN_IDLE;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // ==========================================
    // register bus
    // one wait state: address decoded in cycle 0, answer in cycle 1
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    ctrl_t       ctrl_q;
    ctrl_t       ctrl_d;
    flag_vec_t   mask_q;
    flag_vec_t   mask_d;
    flag_vec_t   flags_q;
    flag_vec_t   flags_d;
    flag_vec_t   flag_set;
    flag_vec_t   flag_clr;
    logic        req;
    logic        done;
    logic [31:0] status_word;
    pwr_state_t  state_q;

    assign req             = avs_read | avs_write;
    assign done            = req & ack_q & clk_en;
    // with the enable low the answer must wait too, or a frozen ack drops the write
    assign avs_waitrequest = req & ~(ack_q & clk_en);
    assign avs_readdata    = rdata_q;
    assign status_word     = {29'h0, state_q == PWR_RESET, power_level1, ~module_ready};

    always_comb begin
        ack_d    = ack_q;
        rdata_d  = rdata_q;
        ctrl_d   = ctrl_q;
        mask_d   = mask_q;
        flag_clr = '0;
        if (clk_en) begin
            ack_d = req & ~ack_q;
            if (avs_read & ~ack_q) begin
                case (avs_address)
                    `OFS_STATUS:  rdata_d = status_word;
                    `OFS_FLAGS:   rdata_d = {19'h0, flags_q};
                    `OFS_MASK:    rdata_d = {19'h0, mask_q};
                    `OFS_CONTROL: rdata_d = {28'h0, ctrl_q};
                    default:      rdata_d = 32'h0;
                endcase
            end
            // read clears only the bits it returned
            if (done & avs_read & (avs_address == `OFS_FLAGS)) begin
                flag_clr = flag_vec_t'(rdata_q[`FLAG_W-1:0]);
            end
            // writes take effect at the completing edge
            if (done & avs_write) begin
                case (avs_address)
                    `OFS_MASK:    mask_d = flag_vec_t'(avs_writedata[`FLAG_W-1:0]);
                    `OFS_CONTROL: ctrl_d = ctrl_t'(avs_writedata[`CTRL_W-1:0]);
                    default:      ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
            ctrl_q  <= ctrl_t'(`CTRL_RESET);
            mask_q  <= flag_vec_t'(`MASK_RESET);
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
            mask_q  <= mask_d;
        end
    end

    // ==========================================
    // power and reset sequencing
    pwr_state_t       state_d;
    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_d;
    logic             lp_exit_q;
    logic             lp_exit_d;
    logic [5:0]       rst_low_q;
    logic [5:0]       rst_low_d;
    logic             rst_seen;
    logic             lp_req;
    logic             ready_evt;

    // both pin and override bit request low power
    assign lp_req   = sync2_q.low_power | ctrl_q.pdown;
    assign rst_seen = (rst_low_q == 6'(`RESET_MIN_CYC));

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        lp_exit_d = lp_exit_q;
        rst_low_d = rst_low_q;
        ready_evt = 1'b0;
        if (clk_en) begin
            // short glitches on the reset pin are ignored
            if (sync2_q.reset_n) begin
                rst_low_d = 6'h0;
            end else if (!rst_seen) begin
                rst_low_d = rst_low_q + 6'h1;
            end
            case (state_q)
                PWR_INIT: begin
                    cnt_d = cnt_q + `CNT_W'(1);
                    if (lp_req) begin
                        state_d = PWR_LOW;
                    end else if (cnt_done(cnt_q, lp_exit_q ? LP_EXIT_CYCLES
                                                            : INIT_CYCLES)) begin
                        state_d   = PWR_READY;
                        ready_evt = 1'b1;
                    end
                end
                PWR_READY: begin
                    if (lp_req) begin
                        state_d = PWR_LOW;
                    end
                end
                PWR_LOW: begin
                    if (!lp_req) begin
                        state_d   = PWR_INIT;
                        cnt_d     = '0;
                        lp_exit_d = 1'b1;
                    end
                end
                PWR_RESET: begin
                    if (sync2_q.reset_n) begin
                        state_d   = PWR_INIT;
                        cnt_d     = '0;
                        lp_exit_d = 1'b0;
                    end
                end
                default: state_d = PWR_INIT;
            endcase
            if (rst_seen) begin
                state_d = PWR_RESET;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q   <= PWR_INIT;
            cnt_q     <= '0;
            lp_exit_q <= 1'b0;
            rst_low_q <= 6'h0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            lp_exit_q <= lp_exit_d;
            rst_low_q <= rst_low_d;
        end
    end

    // ==========================================
    // latched flags and interrupt
    logic irq_n_q;
    logic irq_n_d;
    logic ready_q;
    logic lp_q;
    logic [2:0] sel_q;
    logic ready_n_d;
    logic lp_d;
    logic [2:0] sel_d;

    always_comb begin
        flag_set          = '0;
        flag_set.ready    = ready_evt;
        flag_set.rx_los   = sync2_q.rx_los & ~prev_q.rx_los;
        flag_set.tx_fault = sync2_q.tx_fault & ~prev_q.tx_fault;
        flag_set.other    = sync2_q.other & ~prev_q.other;
        if (!clk_en || state_q == PWR_RESET) begin
            flag_set = '0;
        end
        // set beats a clear in the same cycle; flags hold until read
        flags_d = (flags_q & ~flag_clr) | flag_set;
        // low while any unmasked flag is set
        irq_n_d = clk_en ? ~|(flags_d & ~mask_d) : irq_n_q;
        ready_n_d = clk_en ? (state_d == PWR_READY) : ready_q;
        lp_d      = clk_en ? (state_d == PWR_LOW) : lp_q;
        // selects follow the bits at the completing edge of the write, with the control register
        sel_d     = clk_en ? {ctrl_d.app_sel, ctrl_d.rate_sel} : sel_q;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags_q <= '0;
            irq_n_q <= 1'b1;
            ready_q <= 1'b0;
            lp_q    <= 1'b0;
            sel_q   <= 3'h0;
        end else begin
            flags_q <= flags_d;
            irq_n_q <= irq_n_d;
            ready_q <= ready_n_d;
            lp_q    <= lp_d;
            sel_q   <= sel_d;
        end
    end

    assign interrupt_request_n = irq_n_q;
    assign module_ready        = ready_q;
    assign power_level1        = lp_q;
    assign in_reset            = (state_q == PWR_RESET);
    assign rate_sel_out        = sel_q[1:0];
    assign app_sel_out         = sel_q[2];
endmodule : module_mgmt_event_power_timing
`default_nettype wire

// >>> tb_module_mgmt_event_power_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_module_mgmt_event_power_timing;
    import mgmt_pkg::*;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, rst_go = 1'b1, lp_req = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [7:0]  rst_len = 8'h00;
    logic [11:0] cond_v = 12'h000;
    logic        module_reset_n, low_power_select_pin, interrupt_request_n;
    logic        power_level1, module_ready, in_reset, app_sel_out;
    logic [1:0]  rate_sel_out;
    int          n_fail = 0, checks = 0;
    always #25 ref_clk = ~ref_clk;
    module_mgmt_event_power_timing #(.INIT_CYCLES(50), .LP_EXIT_CYCLES(30)) u_dut (
        .ref_clk, .sys_rst, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .module_reset_n,
        .low_power_select_pin, .rx_los_in(cond_v[3:0]), .tx_fault_in(cond_v[7:4]),
        .other_cond_in(cond_v[11:8]), .interrupt_request_n, .power_level1,
        .module_ready, .in_reset, .rate_sel_out, .app_sel_out);
    host_pins u_host (.ref_clk, .rst_go, .rst_len, .lp_req, .module_reset_n,
        .low_power_select_pin);
    // ==========================================
    // tasks
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // request held up to the edge that completes it; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        // waitrequest is combinational: look where it has settled
        do begin
            @(negedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        // completing edge: data taken here, then released
        @(posedge ref_clk);
        rd        = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (module_ready !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        chk(module_ready, 1'b1);
    endtask : wait_ready
    task automatic pulse(input logic [7:0] len);
        @(posedge ref_clk);
        rst_go  <= 1'b1;
        rst_len <= len;
        @(posedge ref_clk);
        rst_go  <= 1'b0;
    endtask : pulse
    // ==========================================
    // sequence
    initial begin
        cyc(5);
        @(posedge ref_clk) sys_rst <= 1'b0;
        rst_go <= 1'b0;
        rdchk(6'h00, 32'h1);
        rdchk(6'h08, 32'h0);
        wait_ready(80);
        chk(interrupt_request_n, 1'b0);
        rdchk(6'h00, 32'h0);
        rdchk(6'h04, 32'h1);
        cyc(1);
        chk(interrupt_request_n, 1'b1);
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk) cond_v <= 12'h001 << i;
            cyc(6);
            chk(interrupt_request_n, 1'b0);
            @(posedge ref_clk) cond_v <= 12'h000;
            cyc(4);
            rdchk(6'h04, 32'h2 << i);
            cyc(1);
            chk(interrupt_request_n, 1'b1);
        end
        bus(1'b1, 6'h08, 32'h1fff);
        @(posedge ref_clk) cond_v <= 12'h010;
        cyc(6);
        chk(interrupt_request_n, 1'b1);
        bus(1'b1, 6'h08, 32'h0);
        cyc(1);
        chk(interrupt_request_n, 1'b0);
        rdchk(6'h04, 32'h20);
        @(posedge ref_clk) cond_v <= 12'h000;
        bus(1'b1, 6'h0c, 32'he);
        cyc(1);
        chk({rate_sel_out, app_sel_out}, 32'h7);
        rdchk(6'h0c, 32'he);
        bus(1'b1, 6'h0c, 32'h1);
        cyc(2);
        chk(power_level1, 1'b1);
        rdchk(6'h00, 32'h3);
        bus(1'b1, 6'h0c, 32'h0);
        wait_ready(45);
        rdchk(6'h04, 32'h1);
        @(posedge ref_clk) lp_req <= 1'b1;
        cyc(6);
        chk(power_level1, 1'b1);
        @(posedge ref_clk) lp_req <= 1'b0;
        wait_ready(45);
        rdchk(6'h04, 32'h1);
        pulse(8'h14);
        cyc(30);
        chk(in_reset, 1'b0);
        pulse(8'h2d);
        cyc(46);
        chk(in_reset, 1'b1);
        wait_ready(80);
        rdchk(6'h04, 32'h1);
        bus(1'b1, 6'h00, 32'h7);
        rdchk(6'h00, 32'h0);
        rdchk(6'h10, 32'h0);
        report_and_stop();
    end
    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end
endmodule : tb_module_mgmt_event_power_timing
`default_nettype wire
